/* File: pmg_pkg.sv */
// Package: constants and types for power-mode control and peripheral clock gating
`default_nettype none

package pmg_pkg;

    // ==========================================================================
    // Register byte offsets on the APB slave
    localparam logic [7:0] PMG_OFF_PWR_CTRL = 8'h00;
    localparam logic [7:0] PMG_OFF_OSC_CTRL = 8'h04;
    localparam logic [7:0] PMG_OFF_GATE_LOCK = 8'h08;
    localparam logic [7:0] PMG_OFF_GATE_ANALOG = 8'h0C;
    localparam logic [7:0] PMG_OFF_GATE_DMA = 8'h24;
    localparam logic [7:0] PMG_OFF_STATUS = 8'h28;

    // ==========================================================================
    // Field positions
    localparam int PMG_VREG_STBY_BIT = 0;
    localparam int PMG_RET_EN_BIT = 1;
    localparam int PMG_SLEEP_SEL_BIT = 4;
    localparam int PMG_GATE_LOCK_BIT = 11;
    localparam int PMG_RET_FUSE_BIT = 2;

    // ==========================================================================
    // Values after reset
    localparam logic PMG_VREG_STBY_RST = 1'b0;
    localparam logic PMG_RET_EN_RST = 1'b0;
    localparam logic PMG_SLEEP_SEL_RST = 1'b0;
    localparam logic PMG_GATE_LOCK_RST = 1'b0;
    localparam logic PMG_DISABLE_RST = 1'b0;

    // ==========================================================================
    // Peripheral gate map: register number (1..7) and bit of each disable bit
    localparam int PMG_NPERIPH = 35;
    localparam int PMG_GATE_REG [PMG_NPERIPH] = '{
        1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 3, 3, 3,
        4, 4, 4, 5, 5, 5, 5, 5, 5, 5, 5, 5, 5, 6, 6, 7};
    localparam int PMG_GATE_BIT [PMG_NPERIPH] = '{
        0, 12, 20, 0, 1, 2, 24, 25, 26, 27, 8, 9, 10, 11, 12, 13, 14, 15, 16,
        0, 1, 2, 0, 1, 2, 8, 9, 10, 16, 17, 18, 24, 0, 8, 4};
    // First timer (19), calendar clock (32), reference clock out (33)
    localparam logic [PMG_NPERIPH-1:0] PMG_RET_KEEP = 35'h3_0008_0000;

    // ==========================================================================
    // Power modes
    typedef enum logic [2:0] {
        PMG_RUN,
        PMG_IDLE,
        PMG_SLEEP,
        PMG_STBY_SLEEP,
        PMG_RET_SLEEP
    } pmg_mode_type;

    // Wake-up request bundle from the interrupt controller and watchdog
    typedef struct packed {
        logic irq_valid;
        logic [2:0] irq_prio;
        logic [2:0] cpu_prio;
        logic wdt_timeout;
    } pmg_wake_type;

endpackage

`default_nettype wire

/* File: pmg_power_ctrl.sv */
// Module: power-mode sequencer, peripheral clock gating and APB register slave
// ============================================================================
// Overview of operation
// - Regulator standby bit gives Standby Sleep
// - Sleep-capable peripherals also run in Standby Sleep
// - Retention Sleep needs fuse clear and enable
// - Retention keeps timer1, watchdog, calendar, refclock
// - Reset pin wake from retention forces power-on reset
// - Idle halts CPU, clocks keep running
// - Stop-in-idle peripherals halt in Idle
// - Halt with sleep select clear enters Idle
// - Halt with sleep select set enters Sleep
// - Idle exits only on higher-priority interrupt
// - Reset or watchdog time-out also ends Idle
// - Sleep select changes only when system unlocked
// - Disable bit stops its own peripheral's clock
// - Disabled peripheral ignores its register writes
// - Disable bit one disables, resets to zero
// - Lock bit freezes disable registers, writes complete
// - Lock bit changes only when system unlocked
// - Comparators bits 0-2, logic cells 24-27
// - UARTs 0-2, SPI 8-10, USB 24
// - I2C units at bits 16-18
// - Calendar 0, refclock 8, DMA bit 4
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module pmg_power_ctrl #(
    parameter int NPERIPH = pmg_pkg::PMG_NPERIPH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sys_unlocked,
    input wire logic [31:0] power_config_word,
    input wire logic wait_exec,
    input wire pmg_pkg::pmg_wake_type wake_in,
    input wire logic master_clear_pin_n,
    input wire logic [NPERIPH-1:0] stop_in_idle,
    input wire logic [NPERIPH-1:0] sleep_capable,
    input wire logic [NPERIPH-1:0] periph_wr_req,
    input wire logic [5:0] periph_rd_sel,
    input wire logic [31:0] periph_rd_data,
    output logic [NPERIPH-1:0] periph_clk_en,
    output logic [NPERIPH-1:0] periph_wr_en,
    output logic [31:0] periph_rd_data_q,
    output logic cpu_halt,
    output logic regulator_standby,
    output logic retention_reg_on,
    output logic por_req,
    output pmg_pkg::pmg_mode_type power_mode
);

    // ========================================================================
    // Decoding helpers

    // Gate register number 1..7 named by the byte address, low two bits ignored, or zero outside PMG_OFF_GATE_ANALOG..PMG_OFF_GATE_DMA
    function automatic logic [2:0] gate_index(input logic [7:0] addr);
        logic [2:0] idx;
        idx = 3'd0;
        if (addr >= pmg_pkg::PMG_OFF_GATE_ANALOG && addr <= pmg_pkg::PMG_OFF_GATE_DMA)
        begin
            idx = 3'((addr - pmg_pkg::PMG_OFF_GATE_ANALOG) >> 2) + 3'd1;
        end
        return idx;
    endfunction

    // Any mapped register at this address
    function automatic logic is_mapped(input logic [7:0] addr);
        return (addr == pmg_pkg::PMG_OFF_PWR_CTRL) || (addr == pmg_pkg::PMG_OFF_OSC_CTRL)
            || (addr == pmg_pkg::PMG_OFF_GATE_LOCK) || (addr == pmg_pkg::PMG_OFF_STATUS)
            || (gate_index(addr) != 3'd0);
    endfunction

    // ========================================================================
    // Register state
    logic vreg_stby_r;
    logic ret_en_r;
    logic sleep_sel_r;
    logic gate_lock_r;
    logic [NPERIPH-1:0] dis_r;
    logic [NPERIPH-1:0] dis_nxt;
    pmg_pkg::pmg_mode_type mode_r;
    pmg_pkg::pmg_mode_type mode_nxt;
    logic master_clear_pin_s1_r;
    logic master_clear_pin_s2_r;
    logic [31:0] rd_mux;
    logic [NPERIPH-1:0] clk_en_nxt;

    // Write strobe taken at the access edge; pready is high there by design
    logic wr_take;
    logic [2:0] wr_gate;
    logic wake;
    logic ret_fuse_n;
    assign wr_take = psel && penable && pwrite && pready;
    assign wr_gate = gate_index(paddr);
    assign ret_fuse_n = power_config_word[pmg_pkg::PMG_RET_FUSE_BIT];
    // Interrupt must beat the CPU priority strictly; watchdog always wakes
    assign wake = (wake_in.irq_valid && (wake_in.irq_prio > wake_in.cpu_prio))
        || wake_in.wdt_timeout;

    // ========================================================================
    // APB slave: zero-wait, pready registered from the setup cycle and high in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !is_mapped(paddr);
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Read data for every mapped register; holes read as zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (paddr == pmg_pkg::PMG_OFF_PWR_CTRL)
        begin
            rd_mux[pmg_pkg::PMG_VREG_STBY_BIT] = vreg_stby_r;
            rd_mux[pmg_pkg::PMG_RET_EN_BIT] = ret_en_r;
        end
        else if (paddr == pmg_pkg::PMG_OFF_OSC_CTRL)
        begin
            rd_mux[pmg_pkg::PMG_SLEEP_SEL_BIT] = sleep_sel_r;
        end
        else if (paddr == pmg_pkg::PMG_OFF_GATE_LOCK)
        begin
            rd_mux[pmg_pkg::PMG_GATE_LOCK_BIT] = gate_lock_r;
        end
        else if (paddr == pmg_pkg::PMG_OFF_STATUS)
        begin
            rd_mux[2:0] = mode_r;
            rd_mux[3] = ret_fuse_n;
        end
        for (int i = 0; i < NPERIPH; i++)
        begin
            if (wr_gate != 3'd0 && 3'(pmg_pkg::PMG_GATE_REG[i]) == wr_gate)
            begin
                rd_mux[pmg_pkg::PMG_GATE_BIT[i]] = dis_r[i];
            end
        end
    end

    // ========================================================================
    // Power control bits; guarded like the other system registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vreg_stby_r <= pmg_pkg::PMG_VREG_STBY_RST;
            ret_en_r <= pmg_pkg::PMG_RET_EN_RST;
        end
        else if (ce && wr_take && sys_unlocked && paddr == pmg_pkg::PMG_OFF_PWR_CTRL)
        begin
            vreg_stby_r <= pwdata[pmg_pkg::PMG_VREG_STBY_BIT];
            ret_en_r <= pwdata[pmg_pkg::PMG_RET_EN_BIT];
        end
    end

    // Sleep select moves only with the system unlocked
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sleep_sel_r <= pmg_pkg::PMG_SLEEP_SEL_RST;
        end
        else if (ce && wr_take && sys_unlocked && paddr == pmg_pkg::PMG_OFF_OSC_CTRL)
        begin
            sleep_sel_r <= pwdata[pmg_pkg::PMG_SLEEP_SEL_BIT];
        end
    end

    // Gate lock moves only with the system unlocked
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gate_lock_r <= pmg_pkg::PMG_GATE_LOCK_RST;
        end
        else if (ce && wr_take && sys_unlocked && paddr == pmg_pkg::PMG_OFF_GATE_LOCK)
        begin
            gate_lock_r <= pwdata[pmg_pkg::PMG_GATE_LOCK_BIT];
        end
    end

    // Disable bits: a locked write still completes on the bus, it just lands nowhere
    always_comb
    begin
        dis_nxt = dis_r;
        if (wr_take && !gate_lock_r && wr_gate != 3'd0)
        begin
            for (int i = 0; i < NPERIPH; i++)
            begin
                if (3'(pmg_pkg::PMG_GATE_REG[i]) == wr_gate)
                begin
                    dis_nxt[i] = pwdata[pmg_pkg::PMG_GATE_BIT[i]];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dis_r <= {NPERIPH{pmg_pkg::PMG_DISABLE_RST}};
        end
        else if (ce)
        begin
            dis_r <= dis_nxt;
        end
    end

    // ========================================================================
    // Reset pin synchroniser; only the second stage is looked at
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            master_clear_pin_s1_r <= 1'b1;
            master_clear_pin_s2_r <= 1'b1;
        end
        else if (ce)
        begin
            master_clear_pin_s1_r <= master_clear_pin_n;
            master_clear_pin_s2_r <= master_clear_pin_s1_r;
        end
    end

    // ========================================================================
    // Mode sequencer; device reset itself returns to run
    always_comb
    begin
        mode_nxt = mode_r;
        case (mode_r)
            pmg_pkg::PMG_RUN:
            begin
                if (wait_exec)
                begin
                    if (!sleep_sel_r)
                        mode_nxt = pmg_pkg::PMG_IDLE;
                    else if (!ret_fuse_n && ret_en_r)
                        mode_nxt = pmg_pkg::PMG_RET_SLEEP;
                    else if (vreg_stby_r)
                        mode_nxt = pmg_pkg::PMG_STBY_SLEEP;
                    else
                        mode_nxt = pmg_pkg::PMG_SLEEP;
                end
            end
            pmg_pkg::PMG_IDLE:
            begin
                if (wake)
                    mode_nxt = pmg_pkg::PMG_RUN;
            end
            pmg_pkg::PMG_SLEEP, pmg_pkg::PMG_STBY_SLEEP, pmg_pkg::PMG_RET_SLEEP:
            begin
                // A low-priority interrupt restarts peripheral clocks but keeps the CPU halted
                if (mode_r == pmg_pkg::PMG_RET_SLEEP && !master_clear_pin_s2_r)
                    mode_nxt = pmg_pkg::PMG_RUN;
                else if (wake)
                    mode_nxt = pmg_pkg::PMG_RUN;
                else if (wake_in.irq_valid)
                    mode_nxt = pmg_pkg::PMG_IDLE;
            end
            default:
            begin
                mode_nxt = pmg_pkg::PMG_RUN;
            end
        endcase
    end

    // Per-peripheral clock permission from the next mode and next disable bits
    always_comb
    begin
        case (mode_nxt)
            pmg_pkg::PMG_RUN:
                clk_en_nxt = ~dis_nxt;
            pmg_pkg::PMG_IDLE:
                clk_en_nxt = ~dis_nxt & ~stop_in_idle;
            pmg_pkg::PMG_SLEEP, pmg_pkg::PMG_STBY_SLEEP:
                clk_en_nxt = ~dis_nxt & sleep_capable;
            pmg_pkg::PMG_RET_SLEEP:
                clk_en_nxt = ~dis_nxt & pmg_pkg::PMG_RET_KEEP;
            default:
                clk_en_nxt = ~dis_nxt;
        endcase
    end

    // Mode and its registered outputs move together
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_r <= pmg_pkg::PMG_RUN;
            power_mode <= pmg_pkg::PMG_RUN;
            cpu_halt <= 1'b0;
            regulator_standby <= 1'b0;
            retention_reg_on <= 1'b0;
            periph_clk_en <= '0;
        end
        else if (ce)
        begin
            mode_r <= mode_nxt;
            power_mode <= mode_nxt;
            cpu_halt <= mode_nxt != pmg_pkg::PMG_RUN;
            regulator_standby <= mode_nxt == pmg_pkg::PMG_STBY_SLEEP;
            retention_reg_on <= mode_nxt == pmg_pkg::PMG_RET_SLEEP;
            periph_clk_en <= clk_en_nxt;
        end
    end

    // Power-on reset request, one cycle, when the reset pin ends retention
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            por_req <= 1'b0;
        end
        else if (ce)
        begin
            por_req <= (mode_r == pmg_pkg::PMG_RET_SLEEP) && !master_clear_pin_s2_r;
        end
    end

    // ========================================================================
    // Peripheral register access gating; one cycle of latency on both paths
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            periph_wr_en <= '0;
            periph_rd_data_q <= 32'h0000_0000;
        end
        else if (ce)
        begin
            periph_wr_en <= periph_wr_req & ~dis_r;
            periph_rd_data_q <= (int'(periph_rd_sel) < NPERIPH && dis_r[periph_rd_sel])
                ? 32'h0000_0000 : periph_rd_data;
        end
    end

    // ========================================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_idle_entry_mode: assert property (ce && mode_r == pmg_pkg::PMG_RUN && wait_exec
        && !sleep_sel_r |=> mode_r == pmg_pkg::PMG_IDLE && cpu_halt)
        else $error("halt with sleep select clear did not enter idle");
    a_sleep_entry_mode: assert property (ce && mode_r == pmg_pkg::PMG_RUN && wait_exec
        && sleep_sel_r && !(ret_en_r && !ret_fuse_n) |=> (mode_r == pmg_pkg::PMG_SLEEP
        || mode_r == pmg_pkg::PMG_STBY_SLEEP))
        else $error("halt with sleep select set did not enter sleep");
    a_ret_entry_mode: assert property (ce && mode_r == pmg_pkg::PMG_RUN && wait_exec
        && sleep_sel_r |=> (mode_r == pmg_pkg::PMG_RET_SLEEP)
        == $past(ret_en_r && !ret_fuse_n))
        else $error("retention entry does not match enable and fuse");
    a_stby_regulator_on: assert property ((mode_r == pmg_pkg::PMG_STBY_SLEEP)
        == regulator_standby)
        else $error("regulator standby out of step with standby sleep");
    a_idle_gate_mask: assert property ($past(ce) && mode_r == pmg_pkg::PMG_IDLE
        |-> periph_clk_en == (~dis_r & ~$past(stop_in_idle)))
        else $error("idle clock enables ignore stop-in-idle");
    a_ret_gate_mask: assert property (mode_r == pmg_pkg::PMG_RET_SLEEP
        |-> (periph_clk_en & ~pmg_pkg::PMG_RET_KEEP) == '0)
        else $error("non-retained peripheral clocked in retention");
    a_dis_clock_off: assert property ((periph_clk_en & dis_r) == '0)
        else $error("disabled peripheral still clocked");
    a_lock_holds_bits: assert property (ce && wr_take && gate_lock_r && wr_gate != 3'd0
        |=> dis_r == $past(dis_r))
        else $error("locked disable register changed");
    a_sel_needs_unlock: assert property (ce && !sys_unlocked |=> $stable(sleep_sel_r)
        && $stable(gate_lock_r))
        else $error("protected bit changed while system locked");
    a_idle_low_prio: assert property (ce && mode_r == pmg_pkg::PMG_IDLE && !wake
        |=> mode_r == pmg_pkg::PMG_IDLE)
        else $error("idle left without a qualifying wake event");
    a_master_clear_pin_por_pulse: assert property (ce && mode_r == pmg_pkg::PMG_RET_SLEEP && !master_clear_pin_s2_r
        |=> por_req ##1 (!por_req || !ce || mode_r == pmg_pkg::PMG_RET_SLEEP))
        else $error("reset pin wake from retention gave no power-on reset");
    a_wr_blocked: assert property ($past(ce) |-> (periph_wr_en & $past(dis_r)) == '0)
        else $error("write passed to a disabled peripheral");

    c_idle_wake: cover property (mode_r == pmg_pkg::PMG_IDLE ##1 mode_r == pmg_pkg::PMG_RUN);
    c_ret_enter: cover property (mode_r == pmg_pkg::PMG_RUN ##1 retention_reg_on);
    c_locked_write: cover property (wr_take && gate_lock_r && wr_gate != 3'd0);
    c_sleep_to_idle: cover property (mode_r == pmg_pkg::PMG_SLEEP
        ##1 mode_r == pmg_pkg::PMG_IDLE);

endmodule // pmg_power_ctrl

`default_nettype wire

/* File: power_mode_and_module_gating_tb.sv */
// Self-checking testbench for the power-mode sequencer and peripheral clock gating
`timescale 1ns/1ps
`default_nettype none

module power_mode_and_module_gating_tb;
    // ==========================================================================
    // Signals and bookkeeping
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sys_unlocked, wait_exec, err;
    logic master_clear_pin_n, cpu_halt, regulator_standby, retention_reg_on, por_req, seen, ce;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, power_config_word, periph_rd_data, periph_rd_data_q, rd;
    logic [34:0] stop_in_idle, sleep_capable, periph_wr_req, periph_clk_en, periph_wr_en;
    logic [5:0] periph_rd_sel;
    pmg_pkg::pmg_wake_type wake_in;
    pmg_pkg::pmg_mode_type power_mode;
    int fail_count, n_checks;
    // Expected gate register number and bit per peripheral index, kept apart from the design
    localparam int greg [35] = '{1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 3, 3, 3,
        4, 4, 4, 5, 5, 5, 5, 5, 5, 5, 5, 5, 5, 6, 6, 7};
    localparam int gbit [35] = '{0, 12, 20, 0, 1, 2, 24, 25, 26, 27, 8, 9, 10, 11, 12, 13, 14,
        15, 16, 0, 1, 2, 0, 1, 2, 8, 9, 10, 16, 17, 18, 24, 0, 8, 4};

    // ==========================================================================
    // Design under test; clock enable driven so that freezing is exercised too
    pmg_power_ctrl #(.NPERIPH(35)) pmg_power_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sys_unlocked(sys_unlocked), .power_config_word(power_config_word),
        .wait_exec(wait_exec), .wake_in(wake_in), .master_clear_pin_n(master_clear_pin_n),
        .stop_in_idle(stop_in_idle), .sleep_capable(sleep_capable),
        .periph_wr_req(periph_wr_req), .periph_rd_sel(periph_rd_sel),
        .periph_rd_data(periph_rd_data), .periph_clk_en(periph_clk_en),
        .periph_wr_en(periph_wr_en), .periph_rd_data_q(periph_rd_data_q), .cpu_halt(cpu_halt),
        .regulator_standby(regulator_standby), .retention_reg_on(retention_reg_on),
        .por_req(por_req), .power_mode(power_mode));

    // ==========================================================================
    // Clock at 25 ns
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ==========================================================================
    // Helper tasks
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask

    // APB transfer, entered just after a rising edge; waits for pready without assuming latency
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        n = 0;
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        chk("pready", 1, pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle cycle so the next setup never lands in the same time step as this release
        @(posedge pclk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk("prdata", exp, rd);
        chk("pslverr", 0, err);
    endtask

    function automatic logic [7:0] gaddr(input int k);
        return 8'(32'(pmg_pkg::PMG_OFF_GATE_ANALOG) + 4 * (k - 1));
    endfunction

    // Peripheral register write strobe and read path through the gate
    task automatic probe(input int i, input logic en);
        periph_wr_req <= 35'h0_0000_0001 << i;
        periph_rd_sel <= 6'(i);
        periph_rd_data <= 32'hA5C3_5A3C ^ 32'(i);
        @(posedge pclk);
        periph_wr_req <= '0;
        @(posedge pclk);
        chk("periph_wr_en", en, periph_wr_en[i]);
        chk("periph_rd_data_q", en ? (32'hA5C3_5A3C ^ 32'(i)) : 32'h0000_0000, periph_rd_data_q);
    endtask

    // Halt pulse, then the entered mode and its outputs
    task automatic halt_chk(input pmg_pkg::pmg_mode_type m, input logic [34:0] en);
        wait_exec <= 1'b1;
        @(posedge pclk);
        wait_exec <= 1'b0;
        @(posedge pclk);
        chk("power_mode", m, power_mode);
        chk("cpu_halt", 1, cpu_halt);
        chk("periph_clk_en", en, periph_clk_en);
        chk("regulator_standby", m == pmg_pkg::PMG_STBY_SLEEP, regulator_standby);
        chk("retention_reg_on", m == pmg_pkg::PMG_RET_SLEEP, retention_reg_on);
    endtask

    task automatic wake(input pmg_pkg::pmg_wake_type w, input pmg_pkg::pmg_mode_type m);
        wake_in <= w;
        @(posedge pclk);
        @(posedge pclk);
        wake_in <= '0;
        chk("power_mode", m, power_mode);
        chk("cpu_halt", m != pmg_pkg::PMG_RUN, cpu_halt);
        @(posedge pclk);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========================================================================
    // Watchdog: the whole sequence needs under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        $display("[ERR] run expected finish seen timeout");
        final_report();
    end

    // ==========================================================================
    // Main sequence
    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        sys_unlocked = 1'b1;
        power_config_word = 32'h0000_0004;
        wait_exec = 1'b0;
        wake_in = '0;
        master_clear_pin_n = 1'b1;
        stop_in_idle = 35'h5_5555_5555;
        sleep_capable = 35'h0_F0F0_F0F0;
        periph_wr_req = '0;
        periph_rd_sel = 6'h00;
        periph_rd_data = 32'h0000_0000;
        fail_count = 0;
        n_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("periph_clk_en", 35'h7_FFFF_FFFF, periph_clk_en);
        chk("power_mode", pmg_pkg::PMG_RUN, power_mode);
        for (int k = 1; k <= 7; k++)
            rchk(gaddr(k), 32'h0000_0000);
        rchk(pmg_pkg::PMG_OFF_GATE_LOCK, 32'h0000_0000);
        $display("test reset done");
        // Every disable bit in turn: clock gate position, write mask and read zeroing
        for (int i = 0; i < 35; i++)
        begin
            apb(1'b1, gaddr(greg[i]), 32'h0000_0001 << gbit[i]);
            chk("periph_clk_en", 35'(~(35'h0_0000_0001 << i)), periph_clk_en);
            probe(i, 1'b0);
            apb(1'b1, gaddr(greg[i]), 32'h0000_0000);
            probe(i, 1'b1);
        end
        $display("test gate map done");
        // Lock freezes gate registers; lock and sleep select need the system unlock
        apb(1'b1, pmg_pkg::PMG_OFF_GATE_LOCK, 32'h0000_0800);
        rchk(pmg_pkg::PMG_OFF_GATE_LOCK, 32'h0000_0800);
        apb(1'b1, gaddr(7), 32'h0000_0010);
        rchk(gaddr(7), 32'h0000_0000);
        chk("periph_clk_en", 35'h7_FFFF_FFFF, periph_clk_en);
        sys_unlocked <= 1'b0;
        apb(1'b1, pmg_pkg::PMG_OFF_GATE_LOCK, 32'h0000_0000);
        rchk(pmg_pkg::PMG_OFF_GATE_LOCK, 32'h0000_0800);
        apb(1'b1, pmg_pkg::PMG_OFF_OSC_CTRL, 32'h0000_0010);
        rchk(pmg_pkg::PMG_OFF_OSC_CTRL, 32'h0000_0000);
        sys_unlocked <= 1'b1;
        apb(1'b1, pmg_pkg::PMG_OFF_GATE_LOCK, 32'h0000_0000);
        rchk(pmg_pkg::PMG_OFF_GATE_LOCK, 32'h0000_0000);
        apb(1'b0, 8'h2C, 32'h0000_0000);
        chk("pslverr", 1, err);
        $display("test lock done");
        // Idle entry and its wake conditions; equal priority must not wake
        halt_chk(pmg_pkg::PMG_IDLE, ~stop_in_idle);
        wake(8'hA4, pmg_pkg::PMG_IDLE);
        // Clock enable low freezes the sequencer even with a qualifying wake pending
        ce <= 1'b0;
        wake(8'hB4, pmg_pkg::PMG_IDLE);
        ce <= 1'b1;
        wake(8'hB4, pmg_pkg::PMG_RUN);
        halt_chk(pmg_pkg::PMG_IDLE, ~stop_in_idle);
        wake(8'h01, pmg_pkg::PMG_RUN);
        $display("test idle done");
        // Sleep variants
        apb(1'b1, pmg_pkg::PMG_OFF_OSC_CTRL, 32'h0000_0010);
        halt_chk(pmg_pkg::PMG_SLEEP, sleep_capable);
        wake(8'h01, pmg_pkg::PMG_RUN);
        apb(1'b1, pmg_pkg::PMG_OFF_PWR_CTRL, 32'h0000_0001);
        halt_chk(pmg_pkg::PMG_STBY_SLEEP, sleep_capable);
        wake(8'h01, pmg_pkg::PMG_RUN);
        apb(1'b1, pmg_pkg::PMG_OFF_PWR_CTRL, 32'h0000_0003);
        halt_chk(pmg_pkg::PMG_STBY_SLEEP, sleep_capable);
        wake(8'h01, pmg_pkg::PMG_RUN);
        power_config_word <= 32'h0000_0000;
        // Fuse bit now clear, so retention is entered with only bits 19, 32 and 33 clocked
        halt_chk(pmg_pkg::PMG_RET_SLEEP, 35'h3_0008_0000);
        rchk(pmg_pkg::PMG_OFF_STATUS, 32'h0000_0004);
        // Reset pin wake from retention must request a power-on reset
        master_clear_pin_n <= 1'b0;
        seen = 1'b0;
        repeat (6)
        begin
            @(posedge pclk);
            if (por_req === 1'b1)
                seen = 1'b1;
        end
        chk("por_req", 1, seen);
        chk("power_mode", pmg_pkg::PMG_RUN, power_mode);
        master_clear_pin_n <= 1'b1;
        $display("test sleep done");
        final_report();
    end
endmodule // power_mode_and_module_gating_tb

`default_nettype wire
